// ---- testbench/io_pin_model.sv ----
`timescale 1ns/100ps
module io_pin_model #(
	parameter W = 8
) (
	input  logic [W-1:0] drv, // Block drive value
	input  logic [W-1:0] oe,  // Block output enable
	input  logic [W-1:0] ext, // External source level
	output logic [W-1:0] pin  // Resolved pin level
);
	// Driven pins read back their own value, so writes can raise events
	// External source holds a level for as long as asked
	assign pin = (oe & drv) | (~oe & ext);
endmodule // io_pin_model

// ---- testbench/io_port_chk.sv ----
`timescale 1ns/100ps
module io_port_chk #(
	parameter PD_W = 7
) (
	input logic            clk,          // Clock
	input logic            rstn,         // Reset, active low
	input logic [3:0]      regAddr,      // Register address
	input logic            regRd,        // Read strobe
	input logic [7:0]      regRdata,     // Read data
	input logic [PD_W-1:0] portDOut,     // Port D drive
	input logic [PD_W-1:0] portDOe,      // Port D enable
	input logic            timer0CmpB,   // Compare-B wave
	input logic            timer0CmpBEn, // Compare-B enable
	input logic [2:0]      timer0ClkSel, // Timer 0 select
	input logic [2:0]      timer1ClkSel, // Timer 1 select
	input logic            timer0ExtClk, // Timer 0 pin clock
	input logic            timer1ExtClk, // Timer 1 pin clock
	input logic            usartTxEn,    // Transmitter on
	input logic            usartTxData   // Transmit data
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Read data only in the slot after a read strobe
	AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data outside its slot");
	AST_UNMAPPED: assert property ($past(regRd) && $past(regAddr) > 4'hC |-> regRdata == 8'h00)
		else $error("unmapped read not zero");
	AST_PA_HIGH: assert property ($past(regRd) && $past(regAddr) < 4'h3 |-> regRdata[7:3] == 5'h00)
		else $error("port A upper bits not zero");
	AST_PD_HIGH: assert property ($past(regRd) && $past(regAddr) inside {4'h6, 4'h7, 4'h8} |-> !regRdata[7])
		else $error("port D bit 7 not zero");
	// Overrides on Port D and timer pin-clock gating, one register stage behind their cause
	AST_TX_FORCE: assert property (usartTxEn |=> portDOe[1] && portDOut[1] == $past(usartTxData))
		else $error("transmit pin not forced");
	AST_CMPB_OUT: assert property ($past(timer0CmpBEn) && portDOe[5] |-> portDOut[5] == $past(timer0CmpB))
		else $error("compare-B not on driven pin");
	AST_T0_GATE: assert property ($past(timer0ClkSel[2:1]) != 2'b11 |-> !timer0ExtClk)
		else $error("timer 0 pin clock not gated");
	AST_T1_GATE: assert property ($past(timer1ClkSel[2:1]) != 2'b11 |-> !timer1ExtClk)
		else $error("timer 1 pin clock not gated");
endmodule // io_port_chk

bind io_port_with_pin_interrupts io_port_chk #(.PD_W(PD_W)) u_chk (
	.clk(clk), .rstn(rstn), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
	.portDOut(portDOut), .portDOe(portDOe), .timer0CmpB(timer0CmpB),
	.timer0CmpBEn(timer0CmpBEn), .timer0ClkSel(timer0ClkSel), .timer1ClkSel(timer1ClkSel),
	.timer0ExtClk(timer0ExtClk), .timer1ExtClk(timer1ExtClk), .usartTxEn(usartTxEn),
	.usartTxData(usartTxData));

// ---- testbench/io_port_with_pin_interrupts_tb_top.sv ----
`timescale 1ns/100ps
`include "io_port_defines.vh"
module io_port_with_pin_interrupts_tb_top;
	logic       clk = 0, rstn = 0, regWr = 0, regRd = 0;
	logic [3:0] regAddr = 0;
	logic [7:0] regWdata = 0, regRdata, bIn, bOut, bOe, extB = 8'h00;
	logic [2:0] aIn, aOut, aOe, t0Sel = 0, t1Sel = 0;
	logic [6:0] dIn, dOut, dOe, extD = 7'h7F;
	logic       cmpB = 0, cmpBEn = 0, txEn = 0, txData = 0, sync = 0;
	logic       xckOut = 0, xckMst = 0, ckOutEn = 0, ckLvl = 0;
	logic       t0Clk, t1Clk, xckIn, s0Req, irq;
	int         error_cnt = 0, n_checks = 0;
	logic [3:0] rstAddr [10] = '{0, 1, 3, 4, 6, 7, 9, 10, 12, 15};

	always #5 clk = ~clk;

	io_port_with_pin_interrupts DUT (
		.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .portAIn(aIn), .portAOut(aOut), .portAOe(aOe),
		.portBIn(bIn), .portBOut(bOut), .portBOe(bOe), .portDIn(dIn), .portDOut(dOut),
		.portDOe(dOe), .timer0CmpB(cmpB), .timer0CmpBEn(cmpBEn), .timer0ClkSel(t0Sel),
		.timer1ClkSel(t1Sel), .timer0ExtClk(t0Clk), .timer1ExtClk(t1Clk), .usartSync(sync),
		.usartXckOut(xckOut), .usartXckMst(xckMst), .usartXckIn(xckIn), .usartTxEn(txEn),
		.usartTxData(txData), .sysClkOutEn(ckOutEn), .sysClkLevel(ckLvl), .sensed0Req(s0Req),
		.sensed1Req(), .pinChangeReq(), .wakeLevel(), .wakePinChange(), .irq(irq));
	io_pin_model #(.W(3)) port_a_pin_levels (.drv(aOut), .oe(aOe), .ext(3'h0), .pin(aIn));
	io_pin_model #(.W(8)) port_b_pin_levels (.drv(bOut), .oe(bOe), .ext(extB), .pin(bIn));
	io_pin_model #(.W(7)) port_d_pin_levels (.drv(dOut), .oe(dOe), .ext(extD), .pin(dIn));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Strobes last one cycle, data sampled in the slot after
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 0;
		#1 chk(regRdata, e);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Far longer than the sequence needs
	initial begin
		#50000;
		error_cnt++;
		conclude;
	end

	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1;
		repeat (3) @(posedge clk);
		foreach (rstAddr[i]) rd(rstAddr[i], 8'h00);
		wr(`OFS_PORT_A_OUTPUT_LATCH_LATCH, 8'hFF);
		rd(`OFS_PORT_A_OUTPUT_LATCH_LATCH, 8'h07);
		wr(`OFS_PORT_D_OUTPUT_LATCH_DIR, 8'hFF);
		rd(`OFS_PORT_D_OUTPUT_LATCH_DIR, 8'h7F);
		wr(`OFS_PORT_B_OUTPUT_LATCH_LATCH, 8'hA5);
		wr(`OFS_PORT_B_OUTPUT_LATCH_DIR, 8'hF0);
		extB <= 8'h3C;
		w(4);
		chk(bOe, 8'hF0);
		chk(bOut & 8'hF0, 8'hA0);
		rd(`OFS_PORT_B_OUTPUT_LATCH_PINS, 8'hAC);
		$display("register test done");
		// Compare-B only while the direction bit drives
		cmpBEn <= 1;
		cmpB <= 1;
		w(3);
		chk(dOut[5], 1);
		wr(`OFS_PORT_D_OUTPUT_LATCH_DIR, 8'h5F);
		w(3);
		chk(dOe[5], 0);
		cmpBEn <= 0;
		wr(`OFS_PORT_D_OUTPUT_LATCH_DIR, 8'h00);
		t0Sel <= 3'b110;
		t1Sel <= 3'b111;
		sync <= 1;
		w(5);
		chk({t1Clk, t0Clk, xckIn}, 3'b111);
		t0Sel <= 3'b010;
		t1Sel <= 3'b100;
		sync <= 0;
		w(5);
		chk({t1Clk, t0Clk, xckIn}, 3'b000);
		txEn <= 1;
		w(3);
		chk({dOe[1], dOut[1]}, 2'b10);
		txData <= 1;
		w(3);
		chk({dOe[1], dOut[1]}, 2'b11);
		txEn <= 0;
		// Clock pin: master clock only in sync mode, else system clock output
		xckMst <= 1;
		xckOut <= 1;
		sync <= 1;
		wr(`OFS_PORT_D_OUTPUT_LATCH_DIR, 8'h04);
		w(3);
		chk({dOe[2], dOut[2]}, 2'b11);
		sync <= 0;
		ckOutEn <= 1;
		w(3);
		chk({dOe[2], dOut[2]}, 2'b10);
		ckOutEn <= 0;
		xckMst <= 0;
		xckOut <= 0;
		wr(`OFS_PORT_D_OUTPUT_LATCH_DIR, 8'h00);
		w(3);
		chk({dOe[2], dOut[2]}, 2'b00);
		$display("override test done");
		// Low drive on both sensed pins left level events behind
		wr(`OFS_PC_MASK, 8'h01);
		wr(`OFS_EVT_MASK, 8'h04);
		rd(`OFS_EVT_STATUS, 8'h03);
		extB <= 8'h3E;
		w(5);
		chk(irq, 0);
		rd(`OFS_EVT_STATUS, 8'h00);
		extB <= 8'h3F;
		w(5);
		chk(irq, 1);
		rd(`OFS_EVT_STATUS, 8'h04);
		w(1);
		chk(irq, 0);
		wr(`OFS_PORT_B_OUTPUT_LATCH_DIR, 8'hF1);
		wr(`OFS_PORT_B_OUTPUT_LATCH_LATCH, 8'hA4);
		w(5);
		rd(`OFS_EVT_STATUS, 8'h04);
		// Sensed pin 0: any, fall, rise; sensed pin 1 held high
		for (int m = 1; m < 4; m++) begin
			wr(`OFS_IRQ_CTRL, 8'(m));
			extD[2] <= 0;
			w(5);
			rd(`OFS_EVT_STATUS, 8'(m != 3));
			extD[2] <= 1;
			w(5);
			rd(`OFS_EVT_STATUS, 8'(m != 2));
		end
		wr(`OFS_IRQ_CTRL, 8'h00);
		extD[2] <= 0;
		w(5);
		chk(s0Req, 1);
		rd(`OFS_EVT_STATUS, 8'h01);
		rd(`OFS_EVT_STATUS, 8'h01);
		extD[2] <= 1;
		w(5);
		chk(s0Req, 0);
		rd(`OFS_EVT_STATUS, 8'h01);
		rd(`OFS_EVT_STATUS, 8'h00);
		$display("interrupt test done");
		conclude;
	end
endmodule // io_port_with_pin_interrupts_tb_top

// ---- verilog/io_port_defines.vh ----
`ifndef IO_PORT_DEFINES_VH
`define IO_PORT_DEFINES_VH
// Register offsets on the plain register port
`define OFS_PORT_A_OUTPUT_LATCH_LATCH   4'h0
`define OFS_PORT_A_OUTPUT_LATCH_DIR     4'h1
`define OFS_PORT_A_OUTPUT_LATCH_PINS    4'h2
`define OFS_PORT_B_OUTPUT_LATCH_LATCH   4'h3
`define OFS_PORT_B_OUTPUT_LATCH_DIR     4'h4
`define OFS_PORT_B_OUTPUT_LATCH_PINS    4'h5
`define OFS_PORT_D_OUTPUT_LATCH_LATCH   4'h6
`define OFS_PORT_D_OUTPUT_LATCH_DIR     4'h7
`define OFS_PORT_D_OUTPUT_LATCH_PINS    4'h8
`define OFS_IRQ_CTRL      4'h9
`define OFS_PC_MASK       4'hA
`define OFS_EVT_STATUS    4'hB
`define OFS_EVT_MASK      4'hC
// Reset values
`define RST_LATCH         8'h00
`define RST_DIR           8'h00
`define RST_PC_MASK       8'h00
`define RST_IRQ_CTRL      8'h00
`define RST_EVT_MASK      8'h00
// Sense control encodings
`define SENSE_LOW         2'b00
`define SENSE_ANY         2'b01
`define SENSE_FALL        2'b10
`define SENSE_RISE        2'b11
// Control register fields
`define CTRL_SENSE0_LSB   0
`define CTRL_SENSE1_LSB   2
// Event status bits
`define EVT_SENSED0       0
`define EVT_SENSED1       1
`define EVT_PCHANGE       2
`define EVT_WIDTH         3
// Port D bit positions
`define PD_RXD            0
`define PD_TXD            1
`define PD_XCK            2
`define PD_SENSED1        3
`define PD_T0             4
`define PD_TIMER0_COMPARE_B_OUT           5
`endif

// ---- verilog/io_port_with_pin_interrupts.v ----
`timescale 1ns/100ps
`include "io_port_defines.vh"
module io_port_with_pin_interrupts #(
	parameter PA_W = 3,                   // Port A width
	parameter PB_W = 8,                   // Port B width
	parameter PD_W = 7                    // Port D width
) (
	input  wire            clk,           // I/O clock, 100 MHz
	input  wire            rstn,          // Async reset, active low
	input  wire [3:0]      regAddr,       // Register address
	input  wire [7:0]      regWdata,      // Write data
	input  wire            regWr,         // Write strobe
	input  wire            regRd,         // Read strobe
	output reg  [7:0]      regRdata,      // Read data, cycle after strobe
	input  wire [PA_W-1:0] portAIn,       // Port A pin levels
	output reg  [PA_W-1:0] portAOut,      // Port A drive value
	output reg  [PA_W-1:0] portAOe,       // Port A output enable
	input  wire [PB_W-1:0] portBIn,       // Port B pin levels
	output reg  [PB_W-1:0] portBOut,      // Port B drive value
	output reg  [PB_W-1:0] portBOe,       // Port B output enable
	input  wire [PD_W-1:0] portDIn,       // Port D pin levels
	output reg  [PD_W-1:0] portDOut,      // Port D drive value
	output reg  [PD_W-1:0] portDOe,       // Port D output enable
	input  wire            timer0CmpB,    // Timer 0 compare-B waveform
	input  wire            timer0CmpBEn,  // Timer 0 compare-B output enabled
	input  wire [2:0]      timer0ClkSel,  // Timer 0 clock-select field
	input  wire [2:0]      timer1ClkSel,  // Timer 1 clock-select field
	output reg             timer0ExtClk,  // Timer 0 external count input
	output reg             timer1ExtClk,  // Timer 1 external count input
	input  wire            usartSync,     // USART synchronous mode
	input  wire            usartXckOut,   // USART clock, master drive
	input  wire            usartXckMst,   // USART is clock master
	output reg             usartXckIn,    // USART clock from pin
	input  wire            usartTxEn,     // USART transmitter enabled
	input  wire            usartTxData,   // USART transmit data
	input  wire            sysClkOutEn,   // System clock output enabled
	input  wire            sysClkLevel,   // System clock level for output
	output reg             sensed0Req,    // Sensed interrupt 0 request
	output reg             sensed1Req,    // Sensed interrupt 1 request
	output reg             pinChangeReq,  // Pin-change request
	output reg             wakeLevel,     // Async low-level wake, registered
	output reg             wakePinChange, // Async pin-change wake, registered
	output reg             irq            // Masked summary interrupt
);

	// Reset release through two flops
	reg        rstSync1_r;
	reg        rstSync2_r;
	wire       rstnInt = rstSync2_r;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end

	// Software registers
	reg  [PA_W-1:0] latchA_r;
	reg  [PA_W-1:0] dirA_r;
	reg  [PB_W-1:0] latchB_r;
	reg  [PB_W-1:0] dirB_r;
	reg  [PD_W-1:0] latchD_r;
	reg  [PD_W-1:0] dirD_r;
	reg  [7:0]      irqCtrl_r;
	reg  [7:0]      pcMask_r;
	reg  [`EVT_WIDTH-1:0] evtStat_r;
	reg  [`EVT_WIDTH-1:0] evtMask_r;

	// Pin input synchronisers; only stage two is read
	reg  [PA_W-1:0] syncA1_r;
	reg  [PA_W-1:0] syncA2_r;
	reg  [PB_W-1:0] syncB1_r;
	reg  [PB_W-1:0] syncB2_r;
	reg  [PD_W-1:0] syncD1_r;
	reg  [PD_W-1:0] syncD2_r;
	always @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			syncA1_r <= {PA_W{1'b0}};
			syncA2_r <= {PA_W{1'b0}};
			syncB1_r <= {PB_W{1'b0}};
			syncB2_r <= {PB_W{1'b0}};
			syncD1_r <= {PD_W{1'b0}};
			syncD2_r <= {PD_W{1'b0}};
		end else begin
			syncA1_r <= portAIn;
			syncA2_r <= syncA1_r;
			syncB1_r <= portBIn;
			syncB2_r <= syncB1_r;
			syncD1_r <= portDIn;
			syncD2_r <= syncD1_r;
		end
	end

	// Previous sampled levels for edge detection
	reg  [PB_W-1:0] pcPrev_r;
	reg             s0Prev_r;
	reg             s1Prev_r;
	wire            s0Now = syncD2_r[`PD_XCK];
	wire            s1Now = syncD2_r[`PD_SENSED1];
	wire [1:0]      sense0 = irqCtrl_r[`CTRL_SENSE0_LSB +: 2];
	wire [1:0]      sense1 = irqCtrl_r[`CTRL_SENSE1_LSB +: 2];

	// Sense decode per input; inputs are read regardless of direction
	function senseHit;
		input [1:0] mode;
		input       now;
		input       prev;
		begin
			case (mode)
				`SENSE_LOW:  senseHit = ~now;
				`SENSE_ANY:  senseHit = now ^ prev;
				`SENSE_FALL: senseHit = prev & ~now;
				`SENSE_RISE: senseHit = ~prev & now;
				default:     senseHit = 1'b0;
			endcase
		end
	endfunction

	wire       s0Hit = senseHit(sense0, s0Now, s0Prev_r);
	wire       s1Hit = senseHit(sense1, s1Now, s1Prev_r);
	wire [PB_W-1:0] pcToggle = (syncB2_r ^ pcPrev_r) & pcMask_r[PB_W-1:0];
	wire       pcHit = |pcToggle;

	// Raw asynchronous wake terms; they need no clock edge to rise.
	// Registered below only so the outputs come from flops; a sleep
	// controller should also take these combinational terms.
	wire lvlWakeRaw = ((sense0 == `SENSE_LOW) & ~portDIn[`PD_XCK]) |
		((sense1 == `SENSE_LOW) & ~portDIn[`PD_SENSED1]);
	wire pcWakeRaw = |((portBIn ^ pcPrev_r) & pcMask_r[PB_W-1:0]);

	// Read data mux
	reg [7:0] rdNxt;
	always @* begin
		rdNxt = 8'h00;
		case (regAddr)
			`OFS_PORT_A_OUTPUT_LATCH_LATCH: rdNxt[PA_W-1:0] = latchA_r;
			`OFS_PORT_A_OUTPUT_LATCH_DIR:   rdNxt[PA_W-1:0] = dirA_r;
			`OFS_PORT_A_OUTPUT_LATCH_PINS:  rdNxt[PA_W-1:0] = syncA2_r;
			`OFS_PORT_B_OUTPUT_LATCH_LATCH: rdNxt[PB_W-1:0] = latchB_r;
			`OFS_PORT_B_OUTPUT_LATCH_DIR:   rdNxt[PB_W-1:0] = dirB_r;
			`OFS_PORT_B_OUTPUT_LATCH_PINS:  rdNxt[PB_W-1:0] = syncB2_r;
			`OFS_PORT_D_OUTPUT_LATCH_LATCH: rdNxt[PD_W-1:0] = latchD_r;
			`OFS_PORT_D_OUTPUT_LATCH_DIR:   rdNxt[PD_W-1:0] = dirD_r;
			`OFS_PORT_D_OUTPUT_LATCH_PINS:  rdNxt[PD_W-1:0] = syncD2_r;
			`OFS_IRQ_CTRL:    rdNxt = irqCtrl_r;
			`OFS_PC_MASK:     rdNxt = pcMask_r;
			`OFS_EVT_STATUS:  rdNxt[`EVT_WIDTH-1:0] = evtStat_r;
			`OFS_EVT_MASK:    rdNxt[`EVT_WIDTH-1:0] = evtMask_r;
			default:          rdNxt = 8'h00;
		endcase
	end

	// Register writes, reads, and sticky event status
	wire [`EVT_WIDTH-1:0] evtSet = {pcHit, s1Hit, s0Hit};
	wire statRead = regRd & (regAddr == `OFS_EVT_STATUS);
	always @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			latchA_r  <= {PA_W{1'b0}};
			dirA_r    <= {PA_W{1'b0}};
			latchB_r  <= `RST_LATCH;
			dirB_r    <= `RST_DIR;
			latchD_r  <= {PD_W{1'b0}};
			dirD_r    <= {PD_W{1'b0}};
			irqCtrl_r <= `RST_IRQ_CTRL;
			pcMask_r  <= `RST_PC_MASK;
			evtMask_r <= {`EVT_WIDTH{1'b0}};
			evtStat_r <= {`EVT_WIDTH{1'b0}};
			regRdata  <= 8'h00;
			pcPrev_r  <= {PB_W{1'b0}};
			s0Prev_r  <= 1'b0;
			s1Prev_r  <= 1'b0;
		end else begin
			if (regWr) begin
				case (regAddr)
					`OFS_PORT_A_OUTPUT_LATCH_LATCH: latchA_r  <= regWdata[PA_W-1:0];
					`OFS_PORT_A_OUTPUT_LATCH_DIR:   dirA_r    <= regWdata[PA_W-1:0];
					`OFS_PORT_B_OUTPUT_LATCH_LATCH: latchB_r  <= regWdata[PB_W-1:0];
					`OFS_PORT_B_OUTPUT_LATCH_DIR:   dirB_r    <= regWdata[PB_W-1:0];
					`OFS_PORT_D_OUTPUT_LATCH_LATCH: latchD_r  <= regWdata[PD_W-1:0];
					`OFS_PORT_D_OUTPUT_LATCH_DIR:   dirD_r    <= regWdata[PD_W-1:0];
					`OFS_IRQ_CTRL:    irqCtrl_r <= regWdata;
					`OFS_PC_MASK:     pcMask_r  <= regWdata;
					`OFS_EVT_MASK:    evtMask_r <= regWdata[`EVT_WIDTH-1:0];
					default:          ;
				endcase
			end
			// Read of status clears it, but a new event in that cycle wins
			if (statRead)
				evtStat_r <= evtSet;
			else
				evtStat_r <= evtStat_r | evtSet;
			regRdata <= regRd ? rdNxt : 8'h00;
			pcPrev_r <= syncB2_r;
			s0Prev_r <= s0Now;
			s1Prev_r <= s1Now;
		end
	end

	// Pin drive with peripheral overrides on Port D
	wire oc0bOn = timer0CmpBEn & dirD_r[`PD_TIMER0_COMPARE_B_OUT];
	wire xckOn  = usartSync & usartXckMst & dirD_r[`PD_XCK];
	always @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			portAOut     <= {PA_W{1'b0}};
			portAOe      <= {PA_W{1'b0}};
			portBOut     <= {PB_W{1'b0}};
			portBOe      <= {PB_W{1'b0}};
			portDOut     <= {PD_W{1'b0}};
			portDOe      <= {PD_W{1'b0}};
			timer0ExtClk <= 1'b0;
			timer1ExtClk <= 1'b0;
			usartXckIn   <= 1'b0;
			sensed0Req   <= 1'b0;
			sensed1Req   <= 1'b0;
			pinChangeReq <= 1'b0;
			wakeLevel    <= 1'b0;
			wakePinChange <= 1'b0;
			irq          <= 1'b0;
		end else begin
			portAOut <= latchA_r;
			portAOe  <= dirA_r;
			portBOut <= latchB_r;
			portBOe  <= dirB_r;
			portDOut <= latchD_r;
			portDOe  <= dirD_r;
			if (oc0bOn)
				portDOut[`PD_TIMER0_COMPARE_B_OUT] <= timer0CmpB;
			if (xckOn)
				portDOut[`PD_XCK] <= usartXckOut;
			else if (sysClkOutEn) begin
				portDOut[`PD_XCK] <= sysClkLevel;
				portDOe[`PD_XCK]  <= 1'b1;
			end
			if (usartTxEn) begin
				portDOut[`PD_TXD] <= usartTxData;
				portDOe[`PD_TXD]  <= 1'b1;
			end
			// Upper two select bits both one pick the pin as count clock
			timer0ExtClk <= (&timer0ClkSel[2:1]) & syncD2_r[`PD_T0];
			timer1ExtClk <= (&timer1ClkSel[2:1]) & syncD2_r[`PD_TIMER0_COMPARE_B_OUT];
			usartXckIn   <= usartSync & ~usartXckMst & syncD2_r[`PD_XCK];
			// Level mode request follows the pin; it vanishes if released early
			sensed0Req   <= s0Hit;
			sensed1Req   <= s1Hit;
			pinChangeReq <= pcHit;
			wakeLevel    <= lvlWakeRaw;
			wakePinChange <= pcWakeRaw;
			irq          <= |((evtStat_r | evtSet) & evtMask_r);
		end
	end

endmodule // io_port_with_pin_interrupts
